// >>> hdl/cfg_autoload_smbus_access.sv
`timescale 1ns/1ps
module cfg_autoload_smbus_access
   import cfg_pkg::*;
(
   input  wire logic        ref_clk_i,                // Core clock.
   input  wire logic        rstn_i,                   // Async reset, low.
   input  wire logic [2:0]  addr_strap_i,             // Address straps.
   input  wire logic        scl_i,                    // Clock line level.
   output logic             scl_o,                    // Clock drive value.
   output logic             scl_oen_o,                // Low drives clock.
   input  wire logic        mgmt_serial_data_pin_i,   // Data line level.
   output logic             mgmt_serial_data_pin_o,   // Data drive value.
   output logic             mgmt_serial_data_pin_oen_o, // Low drives data.
   input  wire logic        ee_present_i,             // EEPROM fitted.
   output logic             ee_req_o,                 // Word fetch request.
   output logic [7:0]       ee_addr_o,                // Word byte address.
   input  wire logic        ee_ack_i,                 // Word valid pulse.
   input  wire logic [15:0] ee_data_i,                // Fetched word.
   output logic             autoload_done_o,          // Autoload finished.
   input  wire logic [1:0]  cfg_func_i,               // Core read function.
   input  wire logic [7:0]  cfg_off_i,                // Core read offset.
   output logic [31:0]      cfg_rdata_o               // Core read data.
);
   line_if scl_line ();
   line_if sda_line ();

   logic [31:0]  cfg_r [SLOT_COUNT];
   logic [2:0]   strap_r;
   logic         strap_taken_r;
   logic [6:0]   my_addr;
   logic         start_det;
   logic         stop_det;

   smb_state_t   smb_state_r;
   logic [3:0]   bit_cnt_r;
   logic [7:0]   shreg_r;
   logic         rw_r;
   logic         nack_r;
   logic [2:0]   byte_idx_r;
   logic [1:0]   smb_func_r;
   logic [7:0]   smb_off_r;
   logic [31:0]  smb_wdata_r;
   logic         smb_wr_r;
   logic [31:0]  rd_word_r;
   logic         sda_oen_r;
   logic         drive_val_r;
   logic         scl_oen_r;
   logic [4:0]   smb_slot;
   logic [31:0]  smb_rd_word;
   logic         smb_hit;
   logic [1:0]   next_idx;
   logic [7:0]   next_byte;

   load_state_t  al_state_r;
   logic [4:0]   al_idx_r;
   logic [15:0]  al_word_r;
   logic         ee_req_r;
   logic [7:0]   ee_addr_r;
   logic         done_r;
   load_step_t   step;
   load_step_t   next_step;

   logic         wr_en;
   logic [3:0]   wr_slot;
   logic [31:0]  wr_data;
   logic [31:0]  wr_mask;
   logic [4:0]   core_slot;
   logic [31:0]  cfg_rdata_r;

   // Maps a function and offset to a storage slot; bit 4 marks a hit.
   function automatic logic [4:0] slot_of(input logic [1:0] f,
                                          input logic [7:0] off);
      logic [3:0] fx;
      fx = {2'b00, f};
      case (off)
         OFF_USB_PORT1_PHY:  slot_of = {1'b1, SLOT_USB1};
         OFF_USB_PORT2_PHY:  slot_of = {1'b1, SLOT_USB2};
         OFF_USB_PORT3_PHY:  slot_of = {1'b1, SLOT_USB3};
         OFF_USB_PORT4_PHY:  slot_of = {1'b1, SLOT_USB4};
         OFF_ACK_REPLAY:     slot_of = {f != 2'd3, SLOT_ACK + fx};
         OFF_LANE_SELECTION: slot_of = {f == 2'd0, SLOT_LANE};
         OFF_EXPRESS_CAP:    slot_of = {f != 2'd3, SLOT_EXPCAP + fx};
         OFF_DEVICE_CAP:     slot_of = {f != 2'd3, SLOT_DEVCAP + fx};
         default:            slot_of = 5'h00;
      endcase
   endfunction

   assign scl_line.raw = scl_i;
   assign sda_line.raw = mgmt_serial_data_pin_i;

   line_filter u_scl_filter
   (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .line      (scl_line.filt)
   );

   line_filter u_sda_filter
   (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .line      (sda_line.filt)
   );

   // R12: strap capture
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         strap_r       <= 3'h0;
         strap_taken_r <= 1'b0;
      end
      else if (!strap_taken_r)
      begin
         strap_r       <= addr_strap_i;
         strap_taken_r <= 1'b1;
      end
   end

   assign my_addr   = {SMB_ADDR_HI, strap_r};
   assign start_det = sda_line.fall & scl_line.level;
   assign stop_det  = sda_line.rise & scl_line.level;

   assign smb_slot    = slot_of(smb_func_r, smb_off_r);
   assign smb_rd_word = smb_slot[4] ? cfg_r[smb_slot[3:0]] : 32'h0;
   assign smb_hit     = smb_wr_r & smb_slot[4];
   assign next_idx    = byte_idx_r[1:0] + 2'd1;
   assign next_byte   = rd_word_r[8*next_idx +: 8];

   // R9: slave-only transfer engine, it never drives a start
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         smb_state_r <= ST_IDLE;
         bit_cnt_r   <= 4'h0;
         shreg_r     <= 8'h00;
         rw_r        <= 1'b0;
         nack_r      <= 1'b0;
         byte_idx_r  <= 3'h0;
         smb_func_r  <= 2'h0;
         smb_off_r   <= 8'h00;
         smb_wdata_r <= 32'h0;
         smb_wr_r    <= 1'b0;
         rd_word_r   <= 32'h0;
         sda_oen_r   <= 1'b1;
      end
      else
      begin
         smb_wr_r <= 1'b0;
         if (stop_det)
         begin
            smb_state_r <= ST_IDLE;
            sda_oen_r   <= 1'b1;
         end
         else if (start_det)
         begin
            smb_state_r <= ST_ADDR;
            bit_cnt_r   <= 4'h0;
            byte_idx_r  <= 3'h0;
            sda_oen_r   <= 1'b1;
         end
         else
         begin
            unique case (smb_state_r)
               ST_IDLE:
                  sda_oen_r <= 1'b1;
               ST_ADDR, ST_RX:
                  if (scl_line.rise)
                  begin
                     shreg_r   <= {shreg_r[6:0], sda_line.level};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
                  else if (scl_line.fall && bit_cnt_r == BITS_PER_BYTE)
                  begin
                     bit_cnt_r <= 4'h0;
                     if (smb_state_r == ST_ADDR)
                     begin
                        // R15: foreign address is left alone
                        if (shreg_r[7:1] == my_addr)
                        begin
                           rw_r        <= shreg_r[0];
                           sda_oen_r   <= 1'b0;
                           smb_state_r <= ST_ADDR_ACK;
                        end
                        else
                           smb_state_r <= ST_IDLE;
                     end
                     else
                     begin
                        sda_oen_r   <= 1'b0;
                        smb_state_r <= ST_RX_ACK;
                        if (byte_idx_r < SMB_IDX_SAT)
                           byte_idx_r <= byte_idx_r + 3'h1;
                        case (byte_idx_r)
                           3'h0:    smb_func_r <= shreg_r[1:0];
                           3'h1:    smb_off_r  <= shreg_r;
                           3'h6:    smb_wdata_r <= smb_wdata_r;
                           default: smb_wdata_r <= {shreg_r,
                                                    smb_wdata_r[31:8]};
                        endcase
                        // R10: commit on the fourth data byte
                        if (byte_idx_r == SMB_LAST_DATA)
                           smb_wr_r <= 1'b1;
                     end
                  end
               ST_ADDR_ACK:
                  if (scl_line.fall)
                  begin
                     bit_cnt_r <= 4'h0;
                     if (rw_r)
                     begin
                        rd_word_r   <= smb_rd_word;
                        shreg_r     <= smb_rd_word[7:0];
                        sda_oen_r   <= smb_rd_word[7];
                        smb_state_r <= ST_TX;
                     end
                     else
                     begin
                        sda_oen_r   <= 1'b1;
                        smb_state_r <= ST_RX;
                     end
                  end
               ST_RX_ACK:
                  if (scl_line.fall)
                  begin
                     sda_oen_r   <= 1'b1;
                     smb_state_r <= ST_RX;
                  end
               ST_TX:
                  if (scl_line.rise)
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  else if (scl_line.fall)
                  begin
                     if (bit_cnt_r == BITS_PER_BYTE)
                     begin
                        bit_cnt_r   <= 4'h0;
                        sda_oen_r   <= 1'b1;
                        smb_state_r <= ST_TX_ACK;
                     end
                     else
                     begin
                        sda_oen_r <= shreg_r[6];
                        shreg_r   <= {shreg_r[6:0], 1'b0};
                     end
                  end
               ST_TX_ACK:
                  if (scl_line.rise)
                     nack_r <= sda_line.level;
                  else if (scl_line.fall)
                  begin
                     if (nack_r)
                        smb_state_r <= ST_IDLE;
                     else
                     begin
                        byte_idx_r  <= {1'b0, next_idx};
                        shreg_r     <= next_byte;
                        sda_oen_r   <= next_byte[7];
                        smb_state_r <= ST_TX;
                     end
                  end
               default:
                  smb_state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // R13: open lines, the clock is never held low
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         drive_val_r <= 1'b0;
         scl_oen_r   <= 1'b1;
      end
      else
      begin
         drive_val_r <= 1'b0;
         scl_oen_r   <= 1'b1;
      end
   end

   // Autoload sequencer: one EEPROM word per step.
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         al_state_r <= AL_START;
         al_idx_r   <= 5'd0;
         al_word_r  <= 16'h0;
         ee_req_r   <= 1'b0;
         ee_addr_r  <= 8'h00;
         done_r     <= 1'b0;
      end
      else
      begin
         unique case (al_state_r)
            AL_START:
               if (ee_present_i)
               begin
                  ee_req_r   <= 1'b1;
                  ee_addr_r  <= step.ee_addr;
                  al_state_r <= AL_FETCH;
               end
               else
               begin
                  done_r     <= 1'b1;
                  al_state_r <= AL_DONE;
               end
            AL_FETCH:
               if (ee_ack_i)
               begin
                  ee_req_r   <= 1'b0;
                  al_word_r  <= ee_data_i;
                  al_state_r <= AL_APPLY;
               end
            AL_APPLY:
               // A management write in the same cycle goes first.
               if (!smb_hit)
               begin
                  if (al_idx_r == LOAD_LAST)
                  begin
                     done_r     <= 1'b1;
                     al_state_r <= AL_DONE;
                  end
                  else
                  begin
                     al_idx_r   <= al_idx_r + 5'd1;
                     ee_req_r   <= 1'b1;
                     ee_addr_r  <= next_step.ee_addr;
                     al_state_r <= AL_FETCH;
                  end
               end
            AL_DONE:
               done_r <= 1'b1;
         endcase
      end
   end

   // Single write port shared by the management port and autoload.
   always_comb
   begin
      step    = load_step(al_idx_r);
      next_step = load_step(al_idx_r + 5'd1);
      wr_en   = 1'b0;
      wr_slot = 4'h0;
      wr_data = 32'h0;
      wr_mask = 32'h0;
      // R11: read-only fields take management writes too
      if (smb_hit)
      begin
         wr_en   = 1'b1;
         wr_slot = smb_slot[3:0];
         wr_data = smb_wdata_r;
         wr_mask = 32'hffff_ffff;
      end
      // R1: R2: R3: R4: R5: R6: R7: R8: R14: fields from the map
      else if (al_state_r == AL_APPLY)
      begin
         wr_en   = 1'b1;
         wr_slot = step.slot;
         wr_mask = {16'h0, step.mask} << step.shift;
         wr_data = {16'h0, al_word_r & step.mask} << step.shift;
      end
   end

   // R16: both sources land in the same storage
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int i = 0; i < SLOT_COUNT; i++)
            cfg_r[i] <= CFG_RESET;
      end
      else if (wr_en)
         cfg_r[wr_slot] <= (cfg_r[wr_slot] & ~wr_mask) | (wr_data & wr_mask);
   end

   assign core_slot = slot_of(cfg_func_i, cfg_off_i);

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cfg_rdata_r <= 32'h0;
      else
         cfg_rdata_r <= core_slot[4] ? cfg_r[core_slot[3:0]] : 32'h0;
   end

   assign scl_o                      = drive_val_r;
   assign scl_oen_o                  = scl_oen_r;
   assign mgmt_serial_data_pin_o     = drive_val_r;
   assign mgmt_serial_data_pin_oen_o = sda_oen_r;
   assign ee_req_o                   = ee_req_r;
   assign ee_addr_o                  = ee_addr_r;
   assign autoload_done_o            = done_r;
   assign cfg_rdata_o                = cfg_rdata_r;
endmodule

// >>> hdl/cfg_pkg.sv
// Functional notes
// R1: Load ack latency timers into B0h[30:16].
// R2: Load capability ID and next pointer.
// R3: Load port 0 lane mode field.
// R4: Load capability version and port type.
// R5: Load USB port 1 and 2 PHY bytes.
// R6: Load USB port 3 and 4 PHY bytes.
// R7: Load device capability payload and latencies.
// R8: Load captured slot power limit fields.
// R9: Management port is slave only.
// R10: Master reads and writes every RW register.
// R11: Autoloadable read-only registers are also writable.
// R12: Address is 1101 plus three strap bits.
// R13: Clock and data are open two-way lines; the clock is only read here, its output enable is held released.
// R14: Load replay time-out counters into B0h[12:0].
// R15: Ignore and release on foreign addresses.
// R16: Written fields act like loaded ones.
package cfg_pkg;
   // Configuration offsets of the registers held here.
   localparam logic [7:0] OFF_USB_PORT1_PHY  = 8'ha0;
   localparam logic [7:0] OFF_USB_PORT2_PHY  = 8'ha4;
   localparam logic [7:0] OFF_USB_PORT3_PHY  = 8'ha8;
   localparam logic [7:0] OFF_USB_PORT4_PHY  = 8'hac;
   localparam logic [7:0] OFF_ACK_REPLAY     = 8'hb0;
   localparam logic [7:0] OFF_LANE_SELECTION = 8'hc0;
   localparam logic [7:0] OFF_EXPRESS_CAP    = 8'he0;
   localparam logic [7:0] OFF_DEVICE_CAP     = 8'he4;
   // Storage slots; per-function slots add the function number.
   localparam int         SLOT_COUNT     = 14;
   localparam logic [3:0] SLOT_USB1      = 4'h0;
   localparam logic [3:0] SLOT_USB2      = 4'h1;
   localparam logic [3:0] SLOT_USB3      = 4'h2;
   localparam logic [3:0] SLOT_USB4      = 4'h3;
   localparam logic [3:0] SLOT_ACK       = 4'h4;
   localparam logic [3:0] SLOT_LANE      = 4'h7;
   localparam logic [3:0] SLOT_EXPCAP    = 4'h8;
   localparam logic [3:0] SLOT_DEVCAP    = 4'hb;
   localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
   // Fixed upper bits of the management slave address.
   localparam logic [3:0] SMB_ADDR_HI    = 4'hd;
   localparam logic [2:0] SMB_LAST_DATA  = 3'h5;
   localparam logic [2:0] SMB_IDX_SAT    = 3'h6;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam int         FILTER_LEN     = 3;
   localparam logic [4:0] LOAD_LAST     = 5'd22;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_ACK = 3'b011,
      ST_RX       = 3'b010,
      ST_RX_ACK   = 3'b110,
      ST_TX       = 3'b111,
      ST_TX_ACK   = 3'b101
   } smb_state_t;

   typedef enum logic [1:0] {
      AL_START = 2'b00,
      AL_FETCH = 2'b01,
      AL_APPLY = 2'b11,
      AL_DONE  = 2'b10
   } load_state_t;

   typedef struct packed {
      logic [7:0]  ee_addr;
      logic [3:0]  slot;
      logic [4:0]  shift;
      logic [15:0] mask;
   } load_step_t;

   // Autoload map: word address, slot, bit position and word mask.
   function automatic load_step_t load_step(input logic [4:0] i);
      unique case (i)
         5'd0:    load_step = '{8'ha0, 4'h4, 5'd0,  16'h1fff};
         5'd1:    load_step = '{8'ha2, 4'h5, 5'd0,  16'h1fff};
         5'd2:    load_step = '{8'ha4, 4'h6, 5'd0,  16'h1fff};
         5'd3:    load_step = '{8'hb0, 4'h4, 5'd16, 16'h7fff};
         5'd4:    load_step = '{8'hb2, 4'h5, 5'd16, 16'h7fff};
         5'd5:    load_step = '{8'hb4, 4'h6, 5'd16, 16'h7fff};
         5'd6:    load_step = '{8'hb8, 4'h8, 5'd0,  16'hffff};
         5'd7:    load_step = '{8'hba, 4'h9, 5'd0,  16'hffff};
         5'd8:    load_step = '{8'hbc, 4'ha, 5'd0,  16'hffff};
         5'd9:    load_step = '{8'hc0, 4'h7, 5'd0,  16'h007f};
         5'd10:   load_step = '{8'hc8, 4'h8, 5'd16, 16'h00ff};
         5'd11:   load_step = '{8'hca, 4'h9, 5'd16, 16'h00ff};
         5'd12:   load_step = '{8'hcc, 4'ha, 5'd16, 16'h00ff};
         5'd13:   load_step = '{8'hce, 4'h0, 5'd16, 16'h00ff};
         5'd14:   load_step = '{8'hce, 4'h1, 5'd8,  16'hff00};
         5'd15:   load_step = '{8'hd8, 4'hb, 5'd0,  16'h8fc7};
         5'd16:   load_step = '{8'hda, 4'hc, 5'd0,  16'h8fc7};
         5'd17:   load_step = '{8'hdc, 4'hd, 5'd0,  16'h8fc7};
         5'd18:   load_step = '{8'hde, 4'h2, 5'd16, 16'h00ff};
         5'd19:   load_step = '{8'hde, 4'h3, 5'd8,  16'hff00};
         5'd20:   load_step = '{8'he8, 4'hb, 5'd16, 16'h0ffc};
         5'd21:   load_step = '{8'hea, 4'hc, 5'd16, 16'h0ffc};
         5'd22:   load_step = '{8'hec, 4'hd, 5'd16, 16'h0ffc};
         default: load_step = '{8'h00, 4'h0, 5'd0,  16'h0000};
      endcase
   endfunction
endpackage

// >>> hdl/line_if.sv
`timescale 1ns/1ps
interface line_if;
   logic raw;
   logic level;
   logic rise;
   logic fall;
   modport filt (input raw, output level, rise, fall);
   modport user (output raw, input level, rise, fall);
endinterface

// >>> hdl/line_filter.sv
`timescale 1ns/1ps
module line_filter
   import cfg_pkg::*;
(
   input  wire logic ref_clk_i,   // Core clock.
   input  wire logic rstn_i,      // Asynchronous reset, active low.
   line_if.filt      line         // Raw line in, clean level and edges out.
);
   logic [FILTER_LEN-1:0] hist_r;
   logic                  level_r;
   logic                  rise_r;
   logic                  fall_r;

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         hist_r  <= '1;
         level_r <= 1'b1;
         rise_r  <= 1'b0;
         fall_r  <= 1'b0;
      end
      else
      begin
         hist_r <= {hist_r[FILTER_LEN-2:0], line.raw};
         rise_r <= (&hist_r) & ~level_r;
         fall_r <= ~(|hist_r) & level_r;
         // The level moves only after a run of equal samples.
         if (&hist_r)
            level_r <= 1'b1;
         else if (~(|hist_r))
            level_r <= 1'b0;
      end
   end

   assign line.level = level_r;
   assign line.rise  = rise_r;
   assign line.fall  = fall_r;
endmodule

// >>> bench/cfg_props.sv
`timescale 1ns/1ps
module cfg_props
   import cfg_pkg::*;
(
   input wire logic        ref_clk_i, // Clock.
   input wire logic        rstn_i, // Reset.
   input wire logic        scl_i, // Clock line.
   input wire logic        scl_oen_o, // Clock enable.
   input wire logic        mgmt_serial_data_pin_oen_o, // Data enable.
   input wire logic        ee_present_i, // EEPROM fitted.
   input wire logic        ee_req_o, // Fetch request.
   input wire logic [7:0]  ee_addr_o, // Fetch address.
   input wire logic        ee_ack_i, // Fetch answer.
   input wire logic        autoload_done_o, // Load finished.
   input wire logic [1:0]  cfg_func_i, // Read function.
   input wire logic [7:0]  cfg_off_i, // Read offset.
   input wire logic [31:0] cfg_rdata_o // Read data.
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   scl_released_a: assert property (scl_oen_o)
      else $error("Clock line driven");
   sda_edge_a: assert property ($changed(mgmt_serial_data_pin_oen_o)
      |-> !scl_i) else $error("Data moved with clock high");
   req_hold_a: assert property (ee_req_o && !ee_ack_i |=> ee_req_o
      && $stable(ee_addr_o)) else $error("Fetch request moved");
   req_drop_a: assert property (ee_req_o && ee_ack_i |=> !ee_req_o)
      else $error("Fetch request held");
   first_addr_a: assert property ($rose(rstn_i) && ee_present_i
      |-> ##[1:2] ee_req_o && ee_addr_o == 8'ha0)
      else $error("First fetch wrong");
   no_eeprom_a: assert property ($rose(rstn_i) && !ee_present_i
      |-> ##[1:2] autoload_done_o && !ee_req_o)
      else $error("Load not skipped");
   last_done_a: assert property (ee_req_o && ee_ack_i
      && ee_addr_o == 8'hec |-> ##[1:4] autoload_done_o)
      else $error("Done late");
   lane_func_a: assert property (cfg_func_i != 2'h0
      && cfg_off_i == OFF_LANE_SELECTION |=> cfg_rdata_o == 32'h0)
      else $error("Lane field seen");

   cover property (ee_req_o && ee_ack_i && ee_addr_o == 8'hec);
   cover property ($fell(mgmt_serial_data_pin_oen_o));
   cover property ($rose(autoload_done_o));
endmodule

// >>> bench/ee_model.sv
`timescale 1ns/1ps
module ee_model (
   input  wire logic        ref_clk_i, // Clock.
   input  wire logic        rstn_i, // Reset, low.
   input  wire logic        req_i, // Fetch request.
   input  wire logic [7:0]  addr_i, // Word address.
   output logic             ack_o, // Word valid.
   output logic [15:0]      data_o, // Word.
   output logic [7:0]       count_o // Words served.
);
   logic [1:0]  wait_r;
   logic [15:0] word;

   // Each word holds its own address, so a misplaced load shows.
   assign word = {addr_i + 8'h11, addr_i};
   // Between answers the data lines show the inverse word.
   assign data_o = ack_o ? word : ~word;

   // Words with address bit 2 set come three cycles late.
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wait_r  <= 2'h0;
         ack_o   <= 1'b0;
         count_o <= 8'h0;
      end
      else if (req_i && !ack_o && wait_r == {2{addr_i[2]}})
      begin
         wait_r  <= 2'h0;
         ack_o   <= 1'b1;
         count_o <= count_o + 8'h1;
      end
      else
      begin
         ack_o  <= 1'b0;
         wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
      end
   end
endmodule

// >>> bench/tb_cfg_autoload_smbus_access.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("Error %0t: got %h, want %h", $time, got, exp); \
      end \
   end
module tb_cfg_autoload_smbus_access;
   logic        ref_clk_i, rstn_i, ee_present_i, scl_lo, sda_lo, ok;
   logic        scl_o, scl_oen_o, ee_req_o, ee_ack_i, autoload_done_o;
   logic        mgmt_serial_data_pin_o, mgmt_serial_data_pin_oen_o;
   logic [1:0]  cfg_func_i;
   logic [2:0]  addr_strap_i;
   logic [7:0]  cfg_off_i, ee_addr_o, served;
   logic [15:0] ee_data_i;
   logic [31:0] cfg_rdata_o, v;
   int          cmp_count = 0, fail_count = 0;
   // Pulled-up lines; any party may pull them low.
   wire         scl_i = ~scl_lo & (scl_oen_o | scl_o);
   wire         mgmt_serial_data_pin_i = ~sda_lo &
                   (mgmt_serial_data_pin_oen_o | mgmt_serial_data_pin_o);
   localparam logic [6:0] own_addr = {4'hd, 3'h5};
   localparam logic [7:0] offs [9] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0,
                                       8'hb4, 8'hc0, 8'he0, 8'he4};

   cfg_autoload_smbus_access dut (
      .ref_clk_i, .rstn_i, .addr_strap_i, .scl_i, .scl_o, .scl_oen_o,
      .mgmt_serial_data_pin_i, .mgmt_serial_data_pin_o,
      .mgmt_serial_data_pin_oen_o, .ee_present_i, .ee_req_o, .ee_addr_o,
      .ee_ack_i, .ee_data_i, .autoload_done_o, .cfg_func_i, .cfg_off_i,
      .cfg_rdata_o
   );
   ee_model eeprom (
      .ref_clk_i, .rstn_i, .req_i(ee_req_o), .addr_i(ee_addr_o),
      .ack_o(ee_ack_i), .data_o(ee_data_i), .count_o(served)
   );

   // Expected word; the second source lies 10h above the first.
   function automatic logic [31:0] ex(input logic [1:0] f,
                                      input logic [7:0] o);
      logic [7:0]  k, a;
      logic [15:0] t, u;
      k = {5'h0, f, 1'b0};
      a = (o == 8'hb0 ? 8'ha0 + k : o == 8'he0 ? 8'hb8 + k :
           o == 8'he4 ? 8'hd8 + k : o == 8'hc0 ? 8'hc0 :
           8'hce | {o[3], 4'h0});
      t = {a + 8'h11, a};
      u = {a + 8'h21, a + 8'h10};
      case (o)
         8'ha0, 8'ha8: ex = {8'h0, t[7:0], 16'h0};
         8'ha4, 8'hac: ex = {8'h0, t[15:8], 16'h0};
         8'hb0: ex = {1'b0, u[14:0], 3'h0, t[12:0]};
         8'hc0: ex = {25'h0, t[6:0]} & {32{f == 2'h0}};
         8'he0: ex = {8'h0, u[7:0], t};
         8'he4: ex = {4'h0, u[11:2], 2'h0, t & 16'h8fc7};
         default: ex = 32'h0;
      endcase
      if (f == 2'h3 && o[7:4] != 4'ha)
         ex = 32'h0;
   endfunction

   task automatic end_sim();
      $display("Checks %0d, errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic rd(input logic [1:0] f, input logic [7:0] o,
                     output logic [31:0] d);
      @(posedge ref_clk_i);
      cfg_func_i <= f;
      cfg_off_i  <= o;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      d = cfg_rdata_o;
   endtask

   task automatic hp();
      repeat (25) @(posedge ref_clk_i);
   endtask

   // One bit: data set after the fall, sampled late.
   task automatic bt(input logic b, output logic g);
      repeat (8) @(posedge ref_clk_i);
      sda_lo <= ~b;
      hp();
      scl_lo <= 1'b0;
      hp();
      g = mgmt_serial_data_pin_i;
      scl_lo <= 1'b1;
   endtask

   task automatic xb(input logic [7:0] d, input logic m,
                     output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bt(d[i], r[i]);
      bt(m, a);
   endtask

   // s low: start, s high: stop.
   task automatic st(input logic s);
      hp();
      sda_lo <= s;
      hp();
      scl_lo <= 1'b0;
      hp();
      sda_lo <= ~s;
      hp();
      scl_lo <= ~s;
   endtask

   task automatic smb(input logic [6:0] a, input logic [1:0] f,
                      input logic [7:0] o, input logic rw,
                      inout logic [31:0] d, output logic ack);
      logic [7:0] r;
      logic       k;
      st(1'b0);
      xb({a, 1'b0}, 1'b1, r, k);
      ack = ~k;
      xb({6'h0, f}, 1'b1, r, k);
      xb(o, 1'b1, r, k);
      if (rw)
      begin
         st(1'b0);
         xb({a, 1'b1}, 1'b1, r, k);
      end
      for (int i = 0; i < 4; i++)
      begin
         xb(rw ? 8'hff : d[8*i+:8], !(rw && i < 3), r, k);
         if (rw)
            d[8*i+:8] = r;
      end
      st(1'b1);
   endtask

   initial
   begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   initial
   begin
      repeat (60000) @(posedge ref_clk_i);
      fail_count++;
      end_sim();
   end

   initial
   begin
      rstn_i = 1'b0;
      addr_strap_i = 3'h5;
      ee_present_i = 1'b1;
      cfg_func_i = 2'h0;
      cfg_off_i = 8'h0;
      scl_lo = 1'b0;
      sda_lo = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 2000 && autoload_done_o !== 1'b1; i++)
         @(posedge ref_clk_i);
      `CHK(served, 8'h17)
      for (int f = 0; f < 4; f++)
         for (int j = 0; j < 9; j++)
         begin
            rd(2'(f), offs[j], v);
            `CHK(v, ex(2'(f), offs[j]))
         end
      $display("Autoload test done");
      v = 32'hcafe_f00d;
      smb(own_addr, 2'h1, 8'he4, 1'b0, v, ok);
      `CHK(ok, 1'b1)
      rd(2'h1, 8'he4, v);
      `CHK(v, 32'hcafe_f00d)
      rd(2'h0, 8'he4, v);
      `CHK(v, ex(2'h0, 8'he4))
      smb(own_addr, 2'h1, 8'he4, 1'b1, v, ok);
      `CHK(v, 32'hcafe_f00d)
      $display("Access test done");
      v = 32'h0;
      smb(own_addr ^ 7'h01, 2'h1, 8'he4, 1'b0, v, ok);
      `CHK(ok, 1'b0)
      rd(2'h1, 8'he4, v);
      `CHK(v, 32'hcafe_f00d)
      $display("Foreign test done");
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      ee_present_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(negedge ref_clk_i);
      `CHK(autoload_done_o, 1'b1)
      rd(2'h1, 8'he4, v);
      `CHK(v, 32'h0)
      $display("Reset test done");
      end_sim();
   end
endmodule

bind cfg_autoload_smbus_access cfg_props u_props (
   .ref_clk_i, .rstn_i, .scl_i, .scl_oen_o, .mgmt_serial_data_pin_oen_o,
   .ee_present_i, .ee_req_o, .ee_addr_o, .ee_ack_i, .autoload_done_o,
   .cfg_func_i, .cfg_off_i, .cfg_rdata_o
);
